// ==== inc/acpll_map.svh ====
`ifndef ACPLL_MAP_SVH
`define ACPLL_MAP_SVH

// register word addresses on the link (7-bit)
`define ACPLL_ADDR_POWER_GATING 7'h26
`define ACPLL_ADDR_EXTRA_POWER 7'h3C
`define ACPLL_ADDR_CLOCK_SELECT 7'h44
`define ACPLL_ADDR_PLL_PAGER 7'h46

// power_gating_control
`define ACPLL_CORE_CLOCK_OFF_BIT 13
// extra_power_gating
`define ACPLL_PLL_OFF_BIT 9
`define ACPLL_CORE_CLOCK_OFF_RST 1'h1
`define ACPLL_PLL_OFF_RST 1'h1

// clock_select_divide
`define ACPLL_EXT_HIFI_MSB 14
`define ACPLL_EXT_HIFI_LSB 12
`define ACPLL_EXT_VOICE_MSB 11
`define ACPLL_EXT_VOICE_LSB 8
`define ACPLL_DIV_REF_SEL_BIT 7
`define ACPLL_AUX_DIV_MSB 5
`define ACPLL_AUX_DIV_LSB 3
`define ACPLL_IN_B_DOUBLER_BIT 2
`define ACPLL_IN_A_DOUBLER_BIT 1
`define ACPLL_ROOT_SEL_BIT 0
`define ACPLL_DIV_REF_SEL_RST 1'h1

// pll_control_pager
`define ACPLL_N_MSB 15
`define ACPLL_N_LSB 12
`define ACPLL_LOW_BAND_BIT 11
`define ACPLL_SIGMA_DELTA_BIT 10
`define ACPLL_PREDIV_EN_BIT 9
`define ACPLL_PREDIV_RATIO_BIT 8
`define ACPLL_PAGE_SEL_MSB 6
`define ACPLL_PAGE_SEL_LSB 4
`define ACPLL_PAGE_VAL_MSB 3
`define ACPLL_PAGE_VAL_LSB 0

// page numbers and writable masks
`define ACPLL_PAGE_FRAC_TOP 3'h5
`define ACPLL_PAGE_DIV_LOW 3'h6
`define ACPLL_PAGE_DIV_HIGH 3'h7
`define ACPLL_MASK_FRAC_TOP 4'h3
`define ACPLL_MASK_DIV_HIGH 4'h7
`define ACPLL_MASK_FULL 4'hF

// pll model: feedback word is N.K with 22 fraction bits
`define ACPLL_FRAC_BITS 22
// one system tick per four pll output cycles
`define ACPLL_SYS_UNIT 30'h01000000
`define ACPLL_CREDIT_CAP 30'h20000000
`define ACPLL_LOW_BAND_SHIFT 2

`endif

// ==== inc/acpll_pkg.sv ====
package acpll_pkg;
  typedef enum logic [1:0] {
    MUX_RUN,
    MUX_DRAIN,
    MUX_ARM
  } acpll_mux_state_t;

  typedef logic [3:0] acpll_nibble_t;
endpackage

// ==== design/acpll_glitch_mux.sv ====
`timescale 1ns/10ps
module acpll_glitch_mux (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel,
  input wire logic tick0,
  input wire logic tick1,
  output logic tick_out
);
  acpll_pkg::acpll_mux_state_t state_r;
  acpll_pkg::acpll_mux_state_t state_nxt;
  logic cur_r;
  wire old_tick = cur_r ? tick1 : tick0;
  wire new_tick = sel ? tick1 : tick0;

  // old source finishes its period, then output is quiet until the new source edges
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      acpll_pkg::MUX_RUN: begin
        if (sel != cur_r) state_nxt = acpll_pkg::MUX_DRAIN;
      end
      acpll_pkg::MUX_DRAIN: begin
        if (old_tick) state_nxt = acpll_pkg::MUX_ARM;
      end
      acpll_pkg::MUX_ARM: begin
        if (new_tick) state_nxt = acpll_pkg::MUX_RUN;
      end
      default: state_nxt = acpll_pkg::MUX_RUN;
    endcase
  end

  assign tick_out = (state_r != acpll_pkg::MUX_ARM) && old_tick;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= acpll_pkg::MUX_RUN;
      cur_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == acpll_pkg::MUX_DRAIN && old_tick) cur_r <= sel;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_drain_done;
    state_r == acpll_pkg::MUX_DRAIN ##1 state_r == acpll_pkg::MUX_ARM;
  endsequence

  a_mux_quiet_arm: assert property (s_drain_done |-> !tick_out && cur_r == $past(sel))
    else $error("tick passed while arming new source");
  // a fast new source may tick again at once, so only the arming tick itself is held back
  a_mux_no_early: assert property ((state_r == acpll_pkg::MUX_ARM && new_tick) |->
    !tick_out ##1 (state_r == acpll_pkg::MUX_RUN))
    else $error("tick passed on the arming edge");
endmodule

// ==== design/acpll_divider.sv ====
`timescale 1ns/10ps
module acpll_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick_in,
  input wire logic [3:0] code,
  output logic tick_out
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;

  // divide by code plus one; a shrunk code takes effect at once
  assign tick_out = tick_in && (cnt_r >= code);
  assign cnt_nxt = tick_out ? 4'h0 : (cnt_r + 4'h1);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_r <= 4'h0;
    else if (tick_in) cnt_r <= cnt_nxt;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_div_count_reset: assert property (tick_out |=> cnt_r == 4'h0)
    else $error("divider count not restarted");
  a_div_no_early: assert property ((tick_in && cnt_r < code) |-> !tick_out)
    else $error("divider fired before its count");
endmodule

// ==== design/acpll_top.sv ====
`timescale 1ns/10ps
`include "acpll_map.svh"
module acpll_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic MASTER_CLOCK_IN_A,
  input wire logic MASTER_CLOCK_IN_B,
  input wire logic REG_WR_EN,
  input wire logic REG_RD_EN,
  input wire logic [6:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_RD_VALID,
  output logic BITCLK,
  output logic HIFI_CLK,
  output logic VOICE_CLK
);
  // registers
  logic core_clock_off_r;
  logic pll_off_r;
  logic [2:0] ext_hifi_r;
  logic [3:0] ext_voice_r;
  logic divider_reference_select_r;
  logic [2:0] aux_div_r;
  logic input_b_doubler_r;
  logic input_a_doubler_r;
  logic root_clock_select_r;
  logic [3:0] n_div_r;
  logic low_band_reference_r;
  logic sigma_delta_enable_r;
  logic prediv_enable_r;
  logic prediv_ratio_r;
  logic [2:0] page_select_r;
  acpll_pkg::acpll_nibble_t pages_r [0:7];

  function automatic logic [3:0] page_mask(input logic [2:0] pg);
    case (pg)
      `ACPLL_PAGE_FRAC_TOP: page_mask = `ACPLL_MASK_FRAC_TOP;
      `ACPLL_PAGE_DIV_HIGH: page_mask = `ACPLL_MASK_DIV_HIGH;
      default: page_mask = `ACPLL_MASK_FULL;
    endcase
  endfunction

  function automatic logic is_addr(input logic [6:0] a, input logic [6:0] want);
    is_addr = (a == want);
  endfunction

  wire wr_power = REG_WR_EN && is_addr(REG_ADDR, `ACPLL_ADDR_POWER_GATING);
  wire wr_extra = REG_WR_EN && is_addr(REG_ADDR, `ACPLL_ADDR_EXTRA_POWER);
  wire wr_clock = REG_WR_EN && is_addr(REG_ADDR, `ACPLL_ADDR_CLOCK_SELECT);
  wire wr_pager = REG_WR_EN && is_addr(REG_ADDR, `ACPLL_ADDR_PLL_PAGER);
  wire [2:0] wr_page = REG_WDATA[`ACPLL_PAGE_SEL_MSB:`ACPLL_PAGE_SEL_LSB];
  wire [3:0] wr_value = REG_WDATA[`ACPLL_PAGE_VAL_MSB:`ACPLL_PAGE_VAL_LSB];

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      core_clock_off_r <= `ACPLL_CORE_CLOCK_OFF_RST;
      pll_off_r <= `ACPLL_PLL_OFF_RST;
    end else begin
      if (wr_power) core_clock_off_r <= REG_WDATA[`ACPLL_CORE_CLOCK_OFF_BIT];
      if (wr_extra) pll_off_r <= REG_WDATA[`ACPLL_PLL_OFF_BIT];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ext_hifi_r <= 3'h0;
      ext_voice_r <= 4'h0;
      divider_reference_select_r <= `ACPLL_DIV_REF_SEL_RST;
      aux_div_r <= 3'h0;
      input_b_doubler_r <= 1'h0;
      input_a_doubler_r <= 1'h0;
      root_clock_select_r <= 1'h0;
    end else if (wr_clock) begin
      ext_hifi_r <= REG_WDATA[`ACPLL_EXT_HIFI_MSB:`ACPLL_EXT_HIFI_LSB];
      ext_voice_r <= REG_WDATA[`ACPLL_EXT_VOICE_MSB:`ACPLL_EXT_VOICE_LSB];
      divider_reference_select_r <= REG_WDATA[`ACPLL_DIV_REF_SEL_BIT];
      aux_div_r <= REG_WDATA[`ACPLL_AUX_DIV_MSB:`ACPLL_AUX_DIV_LSB];
      input_b_doubler_r <= REG_WDATA[`ACPLL_IN_B_DOUBLER_BIT];
      input_a_doubler_r <= REG_WDATA[`ACPLL_IN_A_DOUBLER_BIT];
      root_clock_select_r <= REG_WDATA[`ACPLL_ROOT_SEL_BIT];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      n_div_r <= 4'h0;
      low_band_reference_r <= 1'h0;
      sigma_delta_enable_r <= 1'h0;
      prediv_enable_r <= 1'h0;
      prediv_ratio_r <= 1'h0;
      page_select_r <= 3'h0;
    end else if (wr_pager) begin
      n_div_r <= REG_WDATA[`ACPLL_N_MSB:`ACPLL_N_LSB];
      low_band_reference_r <= REG_WDATA[`ACPLL_LOW_BAND_BIT];
      sigma_delta_enable_r <= REG_WDATA[`ACPLL_SIGMA_DELTA_BIT];
      prediv_enable_r <= REG_WDATA[`ACPLL_PREDIV_EN_BIT];
      prediv_ratio_r <= REG_WDATA[`ACPLL_PREDIV_RATIO_BIT];
      page_select_r <= wr_page;
    end
  end

  // one write both selects a page and loads it
  genvar gp;
  generate
    for (gp = 0; gp < 8; gp++) begin : g_page
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) pages_r[gp] <= 4'h0;
        else if (wr_pager && wr_page == 3'(gp)) pages_r[gp] <= wr_value & page_mask(wr_page);
      end
    end
  endgenerate

  // fraction lives in pages 0..5, low page first
  wire [21:0] frac_word = {pages_r[5][1:0], pages_r[4], pages_r[3],
                           pages_r[2], pages_r[1], pages_r[0]};
  wire [2:0] pll_hifi = pages_r[`ACPLL_PAGE_DIV_HIGH][2:0];
  wire [3:0] pll_voice = pages_r[`ACPLL_PAGE_DIV_LOW];

  // master clock pins: two flops before any logic, third for edges
  // unpacked so each generated flop process drives only its own element
  logic mclk_s1_r [0:1];
  logic mclk_s2_r [0:1];
  logic mclk_s3_r [0:1];
  wire [1:0] rise;
  wire [1:0] fall;
  wire [1:0] mclk_pin = {MASTER_CLOCK_IN_B, MASTER_CLOCK_IN_A};
  genvar gs;
  generate
    for (gs = 0; gs < 2; gs++) begin : g_sync
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          mclk_s1_r[gs] <= 1'h0;
          mclk_s2_r[gs] <= 1'h0;
          mclk_s3_r[gs] <= 1'h0;
        end else begin
          mclk_s1_r[gs] <= mclk_pin[gs];
          mclk_s2_r[gs] <= mclk_s1_r[gs];
          mclk_s3_r[gs] <= mclk_s2_r[gs];
        end
      end
      assign rise[gs] = mclk_s2_r[gs] & !mclk_s3_r[gs];
      assign fall[gs] = !mclk_s2_r[gs] & mclk_s3_r[gs];
    end
  endgenerate
  // doubling counts both edges of the input
  wire tick_a = rise[0] | (input_a_doubler_r & fall[0]);
  wire tick_b = rise[1] | (input_b_doubler_r & fall[1]);

  logic root_tick;
  acpll_glitch_mux u_root_mux (
    .clk(REF_CLK),
    .rst(RST),
    .sel(root_clock_select_r),
    .tick0(tick_a),
    .tick1(tick_b),
    .tick_out(root_tick)
  );

  // reference predivider
  logic [1:0] prediv_cnt_r;
  wire [1:0] prediv_lim = prediv_ratio_r ? 2'h3 : 2'h1;
  wire prediv_hit = prediv_cnt_r >= prediv_lim;
  wire ref_tick = prediv_enable_r ? (root_tick && prediv_hit) : root_tick;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) prediv_cnt_r <= 2'h0;
    else if (root_tick) prediv_cnt_r <= prediv_hit ? 2'h0 : (prediv_cnt_r + 2'h1);
  end

  // pll as a credit model: each reference edge earns N.K (x4 in low band)
  // output cycles; four of them make one system tick. it cannot outrun
  // REF_CLK, so credit is capped rather than wrapping.
  wire pll_on = !pll_off_r && !core_clock_off_r;
  wire [3:0] n_eff = (n_div_r == 4'h0) ? 4'h1 : n_div_r;
  wire [21:0] k_eff = sigma_delta_enable_r ? frac_word : 22'h0;
  wire [25:0] fb_word = {n_eff, k_eff};
  wire [27:0] fb_mult = low_band_reference_r ? {fb_word, 2'h0} : {2'h0, fb_word};
  logic [29:0] credit_r;
  logic [29:0] credit_nxt;
  wire pll_tick = pll_on && (credit_r >= `ACPLL_SYS_UNIT);
  wire [29:0] credit_add = credit_r + (ref_tick ? {2'h0, fb_mult} : 30'h0);
  wire [29:0] credit_sub = credit_add - (pll_tick ? `ACPLL_SYS_UNIT : 30'h0);
  assign credit_nxt = !pll_on ? 30'h0 :
                      (credit_sub > `ACPLL_CREDIT_CAP) ? `ACPLL_CREDIT_CAP : credit_sub;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) credit_r <= 30'h0;
    else credit_r <= credit_nxt;
  end

  logic sys_tick;
  acpll_glitch_mux u_ref_mux (
    .clk(REF_CLK),
    .rst(RST),
    // inverted so the mux's reset source is the external clock, the reset choice;
    // otherwise it would wait on a pll that is powered down
    .sel(!divider_reference_select_r),
    .tick0(root_tick),
    .tick1(pll_tick),
    .tick_out(sys_tick)
  );
  wire sys_tick_g = sys_tick && !core_clock_off_r;

  wire [2:0] hifi_code = divider_reference_select_r ? ext_hifi_r : pll_hifi;
  wire [3:0] voice_code = divider_reference_select_r ? ext_voice_r : pll_voice;
  logic hifi_tick;
  logic voice_tick;
  acpll_divider u_hifi_div (
    .clk(REF_CLK),
    .rst(RST),
    .tick_in(sys_tick_g),
    .code({1'h0, hifi_code}),
    .tick_out(hifi_tick)
  );
  acpll_divider u_voice_div (
    .clk(REF_CLK),
    .rst(RST),
    .tick_in(sys_tick_g),
    .code(voice_code),
    .tick_out(voice_tick)
  );

  // each output toggles per tick: bit clock is half the system clock
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      BITCLK <= 1'h0;
      HIFI_CLK <= 1'h0;
      VOICE_CLK <= 1'h0;
    end else begin
      if (sys_tick_g) BITCLK <= !BITCLK;
      if (hifi_tick) HIFI_CLK <= !HIFI_CLK;
      if (voice_tick) VOICE_CLK <= !VOICE_CLK;
    end
  end

  // register readback
  wire [15:0] rd_power = 16'(core_clock_off_r) << `ACPLL_CORE_CLOCK_OFF_BIT;
  wire [15:0] rd_extra = 16'(pll_off_r) << `ACPLL_PLL_OFF_BIT;
  wire [15:0] rd_clock = {1'h0, ext_hifi_r, ext_voice_r, divider_reference_select_r,
                          1'h0, aux_div_r, input_b_doubler_r, input_a_doubler_r,
                          root_clock_select_r};
  wire [15:0] rd_pager = {n_div_r, low_band_reference_r, sigma_delta_enable_r,
                          prediv_enable_r, prediv_ratio_r, 1'h0, page_select_r,
                          pages_r[page_select_r]};
  wire [15:0] rd_data = is_addr(REG_ADDR, `ACPLL_ADDR_POWER_GATING) ? rd_power :
                        is_addr(REG_ADDR, `ACPLL_ADDR_EXTRA_POWER) ? rd_extra :
                        is_addr(REG_ADDR, `ACPLL_ADDR_CLOCK_SELECT) ? rd_clock :
                        is_addr(REG_ADDR, `ACPLL_ADDR_PLL_PAGER) ? rd_pager : 16'h0000;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      REG_RDATA <= 16'h0000;
      REG_RD_VALID <= 1'h0;
    end else begin
      REG_RD_VALID <= REG_RD_EN;
      if (REG_RD_EN) REG_RDATA <= rd_data;
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  a_b_doubler_wr: assert property (wr_clock |=> input_b_doubler_r == $past(REG_WDATA[2]))
    else $error("input B doubler not loaded");
  a_a_doubler_edge: assert property ((input_a_doubler_r && fall[0]) |-> tick_a)
    else $error("doubled input A missed a falling edge");
  a_root_sel_wr: assert property (wr_clock |=> root_clock_select_r == $past(REG_WDATA[0]))
    else $error("root select not loaded");
  a_low_band_mult: assert property ((pll_on && low_band_reference_r) |-> fb_mult[1:0] == 2'h0 && fb_mult[27:24] == n_eff)
    else $error("low band multiply wrong");
  a_n_floor: assert property (pll_on |-> fb_word >= 26'h0400000)
    else $error("feedback divide below one");
  a_integer_mode: assert property (!sigma_delta_enable_r |-> fb_word[21:0] == 22'h0)
    else $error("fraction used in integer mode");
  a_prediv_bypass: assert property (!prediv_enable_r |-> ref_tick == root_tick)
    else $error("reference divided while predivider off");
  a_prediv_ratio: assert property ((prediv_enable_r && ref_tick) |-> prediv_cnt_r == prediv_lim)
    else $error("predivider fired at wrong count");
  a_pll_emit_pays: assert property (pll_tick |=> credit_r <= $past(credit_add) - `ACPLL_SYS_UNIT)
    else $error("system tick not charged four pll cycles");
  a_page_load: assert property (wr_pager |=> pages_r[$past(wr_page)] == ($past(wr_value) & page_mask($past(wr_page))))
    else $error("page not loaded");
  a_frac_reserved: assert property (pages_r[5][3:2] == 2'h0)
    else $error("reserved fraction page bits set");
  a_pll_divisors: assert property (!divider_reference_select_r |-> hifi_code == pages_r[7][2:0] && voice_code == pages_r[6])
    else $error("pll mode not using paged divisors");
  a_core_gate: assert property (core_clock_off_r |=> $stable(BITCLK) && $stable(HIFI_CLK) && $stable(VOICE_CLK))
    else $error("clocks ran while core clock off");
  a_pll_off_quiet: assert property (pll_off_r |-> !pll_tick && credit_nxt == 30'h0)
    else $error("pll ran while powered down");
  a_bitclk_toggle: assert property (sys_tick_g |=> BITCLK != $past(BITCLK))
    else $error("bit clock missed a system tick");
  a_div_ref_wr: assert property (wr_clock |=> divider_reference_select_r == $past(REG_WDATA[7]))
    else $error("divider reference not loaded");
endmodule

// ==== bench/acpll_link_partner.sv ====
`timescale 1ns/10ps
// link controller side: receives the bit clock, makes none of its own
module acpll_link_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic bitclk,
  input wire logic clear,
  output int edge_count
);
  logic last_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_r <= 1'h0;
      edge_count <= 0;
    end else begin
      last_r <= bitclk;
      if (clear)
        edge_count <= 0;
      else if (bitclk !== last_r)
        edge_count <= edge_count + 1;
    end
  end
endmodule

// ==== bench/acpll_top_bench.sv ====
`timescale 1ns/10ps
`include "acpll_map.svh"
module acpll_top_bench;
  logic ref_clk, rst, clk_a, clk_b, wr_en, rd_en, rd_valid;
  logic bitclk, hifi_clk, voice_clk, clear;
  logic [6:0] addr;
  logic [15:0] wdata, rdata;
  int errors, tests_run, bit_count, hifi_n, voice_n, cnt_a, cnt_b;

  acpll_top dut_u (
    .REF_CLK(ref_clk),
    .RST(rst),
    .MASTER_CLOCK_IN_A(clk_a),
    .MASTER_CLOCK_IN_B(clk_b),
    .REG_WR_EN(wr_en),
    .REG_RD_EN(rd_en),
    .REG_ADDR(addr),
    .REG_WDATA(wdata),
    .REG_RDATA(rdata),
    .REG_RD_VALID(rd_valid),
    .BITCLK(bitclk),
    .HIFI_CLK(hifi_clk),
    .VOICE_CLK(voice_clk)
  );

  acpll_link_partner link_u (
    .clk(ref_clk),
    .rst(rst),
    .bitclk(bitclk),
    .clear(clear),
    .edge_count(bit_count)
  );

  // both sources run all the time, so a root switch never stalls
  always @(negedge ref_clk) begin
    cnt_a <= (cnt_a == 4) ? 0 : cnt_a + 1;
    if (cnt_a == 4) clk_a <= ~clk_a;
    cnt_b <= (cnt_b == 7) ? 0 : cnt_b + 1;
    if (cnt_b == 7) clk_b <= ~clk_b;
  end

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // window edges and credit residue allow a small slack
  task automatic near(input int got, input int exp);
    tests_run++;
    if (got < exp - 2 || got > exp + 2) begin
      errors++;
      $display("Error at %0t: count %0d expected about %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    addr = a;
    wdata = d;
    wr_en = 1'h1;
    @(negedge ref_clk);
    wr_en = 1'h0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] exp);
    @(negedge ref_clk);
    addr = a;
    rd_en = 1'h1;
    @(negedge ref_clk);
    rd_en = 1'h0;
    chk({15'h0, rd_valid}, 16'h1);
    chk(rdata, exp);
  endtask

  // toggles of each clock output over 400 cycles, after a settling gap
  task automatic measure(input int eb, input int eh, input int ev);
    logic h0, v0;
    hifi_n = 0;
    voice_n = 0;
    repeat (60) @(negedge ref_clk);
    clear = 1'h1;
    @(negedge ref_clk);
    clear = 1'h0;
    h0 = hifi_clk;
    v0 = voice_clk;
    repeat (400) begin
      @(negedge ref_clk);
      if (hifi_clk !== h0) hifi_n++;
      if (voice_clk !== v0) voice_n++;
      h0 = hifi_clk;
      v0 = voice_clk;
    end
    near(bit_count, eb);
    near(hifi_n, eh);
    near(voice_n, ev);
  endtask

  task automatic t_reset;
    rd(`ACPLL_ADDR_POWER_GATING, 16'h2000);
    rd(`ACPLL_ADDR_EXTRA_POWER, 16'h0200);
    rd(`ACPLL_ADDR_CLOCK_SELECT, 16'h0080);
    rd(`ACPLL_ADDR_PLL_PAGER, 16'h0000);
    measure(0, 0, 0);
  endtask

  task automatic t_regs;
    wr(`ACPLL_ADDR_CLOCK_SELECT, 16'h3A87);
    rd(`ACPLL_ADDR_CLOCK_SELECT, 16'h3A87);
    wr(7'h10, 16'hFFFF);
    rd(7'h10, 16'h0000);
  endtask

  task automatic t_pages;
    logic [3:0] m;
    for (int p = 0; p < 8; p++) begin
      m = (p == 5) ? 4'h3 : (p == 7) ? 4'h7 : 4'hF;
      wr(`ACPLL_ADDR_PLL_PAGER, {9'h0, p[2:0], 4'hF});
      rd(`ACPLL_ADDR_PLL_PAGER, {9'h0, p[2:0], m});
    end
    for (int p = 0; p < 8; p++) begin
      wr(`ACPLL_ADDR_PLL_PAGER, {9'h0, p[2:0], 4'h0});
    end
    rd(`ACPLL_ADDR_PLL_PAGER, 16'h0070);
  endtask

  task automatic t_ext;
    wr(`ACPLL_ADDR_POWER_GATING, 16'h0000);
    wr(`ACPLL_ADDR_CLOCK_SELECT, 16'h3480);
    measure(40, 10, 8);
    wr(`ACPLL_ADDR_CLOCK_SELECT, 16'h3482);
    measure(80, 20, 16);
    wr(`ACPLL_ADDR_CLOCK_SELECT, 16'h3485);
    measure(50, 12, 10);
    wr(`ACPLL_ADDR_CLOCK_SELECT, 16'h3481);
    measure(25, 6, 5);
    wr(`ACPLL_ADDR_POWER_GATING, 16'h2000);
    measure(0, 0, 0);
    wr(`ACPLL_ADDR_POWER_GATING, 16'h0000);
  endtask

  task automatic t_pll;
    wr(`ACPLL_ADDR_CLOCK_SELECT, 16'h0000);
    wr(`ACPLL_ADDR_PLL_PAGER, 16'h8071);
    wr(`ACPLL_ADDR_PLL_PAGER, 16'h8063);
    measure(0, 0, 0);
    wr(`ACPLL_ADDR_EXTRA_POWER, 16'h0000);
    measure(80, 40, 20);
    wr(`ACPLL_ADDR_PLL_PAGER, 16'h8263);
    measure(40, 20, 10);
    wr(`ACPLL_ADDR_PLL_PAGER, 16'h8363);
    measure(20, 10, 5);
    // divide codes 0 and 1 are kept out of integer mode, so the modulator stays on here
    wr(`ACPLL_ADDR_PLL_PAGER, 16'h0463);
    measure(10, 5, 2);
    wr(`ACPLL_ADDR_PLL_PAGER, 16'h1463);
    measure(10, 5, 2);
    wr(`ACPLL_ADDR_PLL_PAGER, 16'h1C63);
    measure(40, 20, 10);
    wr(`ACPLL_ADDR_PLL_PAGER, 16'h5052);
    measure(50, 25, 12);
    wr(`ACPLL_ADDR_PLL_PAGER, 16'h5452);
    measure(55, 27, 13);
  endtask

  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    errors = 0;
    tests_run = 0;
    cnt_a = 0;
    cnt_b = 0;
    clk_a = 1'h0;
    clk_b = 1'h0;
    wr_en = 1'h0;
    rd_en = 1'h0;
    clear = 1'h0;
    addr = 7'h00;
    wdata = 16'h0000;
    rst = 1'h1;
    repeat (6) @(negedge ref_clk);
    rst = 1'h0;
    t_reset();
    t_regs();
    t_pages();
    t_ext();
    t_pll();
    summarize();
  end

  initial begin
    #400000;
    errors++;
    $display("Error at %0t: run did not finish", $time);
    summarize();
  end
endmodule
